// ===== dv/swppm_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module swppm_slave_model (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic tx_out,
    input wire logic [1:0] mode,
    input wire logic [7:0] pull,
    output logic rx_in
);
    int cnt;
    int low;
    logic drv;
    logic err;
    logic h0;
    logic h1;
    logic [5:0] slot;
    // frame time counted from the first dominant slot seen on the wire;
    // idle again just past the end of frame, so close frames are caught
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) cnt <= 640;
        else if (cnt >= 640 && !tx_out) cnt <= 0;
        else if (cnt < 640) cnt <= cnt + 1;
    end
    // length of the current dominant stretch on the wire
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) low <= 0;
        else low <= tx_out ? 0 : low + 1;
    end
    assign slot = 6'((cnt + 2) / 16);
    // two looks per push slot; any error or a long low keeps it silent
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            err <= 1'b0;
            h0 <= 1'b1;
            h1 <= 1'b1;
        end else if (cnt >= 640) begin
            err <= 1'b0;
        end else if (low >= 128) begin
            err <= 1'b1;
        end else if (slot < 6'd23 && cnt % 16 == 3) begin
            h0 <= tx_out;
        end else if (slot < 6'd23 && cnt % 16 == 10) begin
            h1 <= tx_out;
            err <= err || tx_out != h0
                || (slot < 6'd4 && tx_out != (slot == 6'd3))
                || (slot > 6'd3 && !slot[0] && tx_out == h1);
        end
    end
    // mode 0 answers, 1 stays silent (failed frame), 2 jams the sync slot
    always_comb begin
        drv = 1'b1;
        if (slot == 6'd3 && mode == 2'd2) drv = 1'b0;
        if (slot >= 6'd23 && slot < 6'd31 && mode != 2'd1 && !err) begin
            drv = pull[3'(slot - 6'd23)];
        end
        if (slot >= 6'd31 && slot < 6'd39 && mode != 2'd1 && !err) begin
            drv = slot[0];
        end
    end
    // open drain with pull-up: a released wire reads recessive
    assign rx_in = tx_out & drv;
endmodule : swppm_slave_model
`default_nettype wire

// ===== dv/swppm_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module swppm_chk (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire swppm_pkg::swppm_req_s req,
    input wire logic [swppm_pkg::DATA_W-1:0] rdata,
    input wire logic rx_in,
    input wire logic tx_out
);
    logic [7:0] c1_r;
    logic [7:0] c2_r;
    logic [7:0] bl_r;
    logic go;
    // shadow controls; frame timing is judged only while baud low is one
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            c1_r <= 8'h00;
            c2_r <= 8'h00;
            bl_r <= 8'h04;
        end else if (req.wr) begin
            if (req.addr == 8'h52) c1_r <= req.wdata;
            if (req.addr == 8'h53) c2_r <= req.wdata;
            if (req.addr == 8'h51) bl_r <= req.wdata;
        end
    end
    assign go = c1_r[5] && !c1_r[0] && c2_r[3] && bl_r == 8'h01;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_start;
        !tx_out[*8] ##[30:45] tx_out;
    endsequence
    sequence s_sync0;
        ##[14:18] !tx_out;
    endsequence
    a_push_start: assert property (
        req.wr && req.addr == 8'h57 && go |=> s_start ##0 s_sync0)
        else $error("push field start or sync wrong");
    a_break_low: assert property (
        req.wr && req.addr == 8'h53 && req.wdata[0] && go |=> !tx_out[*8])
        else $error("break did not hold line low");
    a_bus_off: assert property (
        req.wr && req.addr == 8'h52 && req.wdata[5:0] == 6'h00
        |-> ##[1:2] tx_out) else $error("bus mode off left line driven");
    a_rd_quiet: assert property (!$past(req.rd) |-> rdata == 8'h00)
        else $error("read data outside read cycle");
    a_stat2_pad: assert property (
        $past(req.rd) && $past(req.addr) == 8'h55 |-> rdata[7:3] == 5'h00)
        else $error("status two spare bits set");
    a_data_hi: assert property (
        $past(req.rd) && $past(req.addr) == 8'h56 |-> rdata == 8'h00)
        else $error("data high not zero");
    a_unmapped: assert property (
        $past(req.rd) && ($past(req.addr) < 8'h50 || $past(req.addr) > 8'h57)
        |-> rdata == 8'h00) else $error("unmapped read not zero");
    a_stat1_pad: assert property (
        $past(req.rd) && $past(req.addr) == 8'h54 |-> !rdata[3])
        else $error("status one bit 3 set");
endmodule : swppm_chk
bind swppm_top swppm_chk u_chk (.sys_clk(sys_clk), .rstn(rstn), .req(req),
    .rdata(rdata), .rx_in(rx_in), .tx_out(tx_out));
`default_nettype wire

// ===== dv/test_single_wire_push_pull_master.sv
`timescale 1ns/10ps
`default_nettype none
module test_single_wire_push_pull_master;
    logic sys_clk = 0;
    logic rstn = 0;
    swppm_pkg::swppm_req_s req = '0;
    logic [7:0] rdata, pb, p;
    logic rx_in, tx_out;
    logic [1:0] mode = 0;
    logic [7:0] pull = 8'h5a;
    logic [15:0] q[$];
    logic [15:0] e;
    logic [7:0] ra[8] = '{8'h50, 8'h51, 8'h52, 8'h53,
        8'h54, 8'h55, 8'h56, 8'h60};
    logic [7:0] rv[8] = '{8'h00, 8'h04, 8'h00, 8'h00,
        8'hC0, 8'h00, 8'h00, 8'h00};
    int num_errors = 0, checks = 0, seed = 84916;
    always #25 sys_clk = ~sys_clk;
    swppm_top dut (.sys_clk(sys_clk), .rstn(rstn), .req(req), .rdata(rdata),
        .rx_in(rx_in), .tx_out(tx_out));
    swppm_slave_model slv (.sys_clk(sys_clk), .rstn(rstn), .tx_out(tx_out),
        .mode(mode), .pull(pull), .rx_in(rx_in));
    task automatic cmp(string n, logic [7:0] x, logic [7:0] y);
        checks++;
        if (x !== y) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", n, x, y);
        end
    endtask : cmp
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    // one idle cycle after each strobe keeps strobes single
    task automatic wr(logic [7:0] a, logic [7:0] d);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        req <= '0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] m, logic [7:0] x);
        q.push_back({m, x});
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk);
        req <= '0;
        @(posedge sys_clk);
    endtask : rd
    // read data stand only in the cycle after the strobe
    always @(posedge sys_clk) if (req.rd === 1'b1) begin
        @(negedge sys_clk);
        e = q.pop_front();
        cmp("rdata", e[7:0] & e[15:8], rdata & e[15:8]);
    end
    // sample every push slot at its middle, modulus one gives 16 cycles
    task automatic frame(logic [7:0] pay, logic [1:0] md);
        logic [22:0] lv;
        lv = {2'b10, 16'h0000, 5'b01000};
        for (int k = 0; k < 8; k++) lv[5+2*k] = !pay[k];
        for (int k = 0; k < 8; k++) lv[6+2*k] = pay[k];
        mode <= md;
        wr(8'h57, pay);
        repeat (8) @(posedge sys_clk);
        for (int s = 0; s < 23; s++) begin
            #1 cmp("tx_slot", 8'(lv[s]), 8'(tx_out));
            repeat (16) @(posedge sys_clk);
        end
        repeat (300) @(posedge sys_clk);
    endtask : frame
    initial begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1;
        @(posedge sys_clk);
        foreach (ra[i]) rd(ra[i], 8'hFF, rv[i]);
        $display("reset values done");
        wr(8'h51, 8'h01);
        wr(8'h52, 8'h20);
        wr(8'h53, 8'h0C);
        for (int i = 0; i < 3; i++) begin
            p = 8'($random(seed));
            pb = 8'($random(seed));
            if (pb == 8'h00 || pb == 8'hFF) pb = 8'h3c;
            pull <= pb;
            frame(p, 2'd0);
            rd(8'h54, 8'hF4, 8'hF0);
            rd(8'h57, 8'hFF, pb);
            rd(8'h55, 8'h07, 8'h02);
        end
        frame(8'hE1, 2'd1);
        rd(8'h54, 8'hF4, 8'hF0);
        rd(8'h57, 8'hFF, 8'hFF);
        rd(8'h55, 8'h07, 8'h04);
        frame(8'h1B, 2'd2);
        rd(8'h54, 8'hF4, 8'hF4);
        rd(8'h57, 8'h00, 8'h00);
        rd(8'h54, 8'hF4, 8'hD0);
        $display("frames done");
        wr(8'h53, 8'h0D);
        repeat (304) @(posedge sys_clk);
        #1 cmp("break_low", 8'h00, {7'h0, tx_out});
        repeat (32) @(posedge sys_clk);
        #1 cmp("break_end", 8'h01, {7'h0, tx_out});
        repeat (400) @(posedge sys_clk);
        wr(8'h57, 8'h96);
        repeat (100) @(posedge sys_clk);
        wr(8'h52, 8'h00);
        #1 cmp("abort_tx", 8'h01, {7'h0, tx_out});
        @(posedge sys_clk);
        wr(8'h52, 8'h21);
        #1 cmp("tx_invert", 8'h00, {7'h0, tx_out});
        $display("break and abort done");
        complete_run();
    end
    // guard against a hang well beyond the expected run length
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        $display("watchdog expired");
        complete_run();
    end
endmodule : test_single_wire_push_pull_master
`default_nettype wire

// ===== rtl/swppm_pkg.sv
`default_nettype none
package swppm_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int BR_W = 13;
    localparam int SLOT_W = 6;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_BAUD_HI = 8'h50;
    localparam logic [7:0] OFS_BAUD_LO = 8'h51;
    localparam logic [7:0] OFS_CTL_ONE = 8'h52;
    localparam logic [7:0] OFS_CTL_TWO = 8'h53;
    localparam logic [7:0] OFS_STAT_ONE = 8'h54;
    localparam logic [7:0] OFS_STAT_TWO = 8'h55;
    localparam logic [7:0] OFS_DATA_HI = 8'h56;
    localparam logic [7:0] OFS_DATA_LO = 8'h57;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTL1_BUS_MODE = 5;
    localparam int CTL1_TX_INV = 0;
    localparam int CTL2_TE = 3;
    localparam int CTL2_RE = 2;
    localparam int CTL2_SBK = 0;
    localparam int ST1_TDRE = 7;
    localparam int ST1_TC = 6;
    localparam int ST1_RDRF = 5;
    localparam int ST1_IDLE = 4;
    localparam int ST1_MISMATCH = 2;
    localparam int ST2_RX_ACTIVE = 0;
    localparam int ST2_FRAME_OK = 1;
    localparam int ST2_FRAME_FAIL = 2;
    localparam int BAUD_HI_BITS = 5;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] BAUD_LO_RST = 8'h04;
    localparam logic [7:0] BAUD_HI_RST = 8'h00;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] STAT_ONE_RST = 8'hC0;
    localparam logic [7:0] PULL_ONES = 8'hFF;
    localparam logic [7:0] PULL_ZEROS = 8'h00;

    // ------------------------------------------------------------
    // frame layout, counted in time slots
    // ------------------------------------------------------------
    localparam int SUBSLOTS = 16;
    localparam int PRESCALE_STEP_HZ = 1280000;
    localparam int MAX_SLAVES = 8;
    localparam logic [SLOT_W-1:0] START_SLOTS = 6'd3;
    localparam logic [SLOT_W-1:0] SYNC_SLOT = 6'd3;
    localparam logic [SLOT_W-1:0] FIRST_BIT_SLOT = 6'd5;
    localparam logic [SLOT_W-1:0] PULL_SYNC_SLOT = 6'd21;
    localparam logic [SLOT_W-1:0] LAST_PUSH_SLOT = 6'd22;
    localparam logic [SLOT_W-1:0] PULL_BITS = 6'd8;
    localparam logic [SLOT_W-1:0] EOF_SLOTS = 6'd8;
    localparam logic [SLOT_W-1:0] BREAK_SLOTS = 6'd20;
    localparam logic [3:0] EOF_MIN_EDGES = 4'd4;

    // ------------------------------------------------------------
    // register port request
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } swppm_req_s;

endpackage : swppm_pkg
`default_nettype wire

// ===== rtl/swppm_slot_timer.sv
`timescale 1ns/10ps
`default_nettype none
module swppm_slot_timer #(
    parameter int BR_W = 13
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic restart,
    input wire logic [BR_W-1:0] modulus,
    output logic slot_mid,
    output logic slot_end
);

    localparam int CNT_W = BR_W + 4;

    initial begin
        if (BR_W < 1 || BR_W > 16) begin
            $error("swppm_slot_timer: unsupported BR_W");
        end
    end

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] slot_len;
    logic [CNT_W-1:0] half_len;

    // one slot is sixteen times the modulus, half a bit of 16*2n
    assign slot_len = {modulus, 4'b0000};
    assign half_len = {1'b0, modulus, 3'b000};

    // a zero modulus stops the generator, so no slot ever ends
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else if (restart || !run || modulus == '0) begin
            cnt_r <= '0;
        end else if (cnt_r == slot_len - 1'b1) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign slot_mid = run && !restart && modulus != '0 && cnt_r == half_len;
    assign slot_end = run && !restart && modulus != '0
                      && cnt_r == slot_len - 1'b1;

endmodule : swppm_slot_timer
`default_nettype wire

// ===== rtl/swppm_top.sv
`timescale 1ns/10ps
`default_nettype none
module swppm_top #(
    parameter int BR_W = swppm_pkg::BR_W
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire swppm_pkg::swppm_req_s req,
    output logic [swppm_pkg::DATA_W-1:0] rdata,
    input wire logic rx_in,
    output logic tx_out
);

    initial begin
        if (BR_W != swppm_pkg::BR_W) begin
            $error("swppm_top: BR_W must match the baud register width");
        end
        if (swppm_pkg::MAX_SLAVES != 8) begin
            $error("swppm_top: address field is three bits wide");
        end
    end

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PUSH,
        ST_PULL,
        ST_EOF,
        ST_BREAK
    } swppm_state_e;

    // ------------------------------------------------------------
    // registers and decode
    // ------------------------------------------------------------
    logic [7:0] baud_hi_r;
    logic [7:0] baud_lo_r;
    logic [7:0] ctl_one_r;
    logic [7:0] ctl_two_r;
    logic [7:0] payload_r;
    logic [7:0] rx_data_r;
    logic tdre_r;
    logic tc_r;
    logic rdrf_r;
    logic idle_r;
    logic mismatch_r;
    logic rdrf_snap_r;
    logic mismatch_snap_r;
    logic rx_active_r;
    logic frame_ok_r;
    logic frame_fail_r;
    logic [7:0] rdata_r;
    logic tx_r;
    swppm_state_e state_r;
    logic [swppm_pkg::SLOT_W-1:0] slot_idx_r;
    logic [7:0] shift_r;
    logic eof_prev_r;
    logic eof_high_r;
    logic [3:0] eof_edges_r;

    logic wr_data;
    logic wr_ctl_two;
    logic rd_stat;
    logic rd_data;
    logic bus_mode;
    logic frame_start;
    logic break_start;
    logic slot_mid;
    logic slot_end;
    logic [BR_W-1:0] modulus;
    logic sent_level;
    logic rx_path;
    logic push_err;
    logic pull_done;
    logic eof_done;
    logic tdre_set;
    logic frame_end;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // level that the device puts on the wire in a given push slot
    function automatic logic push_level(
        input logic [swppm_pkg::SLOT_W-1:0] idx,
        input logic [7:0] pay
    );
        logic [swppm_pkg::SLOT_W-1:0] rel;
        logic b;
        rel = idx - swppm_pkg::FIRST_BIT_SLOT;
        b = pay[rel[3:1]];
        if (idx < swppm_pkg::START_SLOTS) begin
            push_level = 1'b0;
        end else if (idx < swppm_pkg::FIRST_BIT_SLOT) begin
            push_level = (idx == swppm_pkg::SYNC_SLOT);
        end else if (idx < swppm_pkg::PULL_SYNC_SLOT) begin
            push_level = rel[0] ? b : ~b;
        end else begin
            push_level = (idx != swppm_pkg::PULL_SYNC_SLOT);
        end
    endfunction : push_level

    assign wr_data = req.wr && hit(req.addr, swppm_pkg::OFS_DATA_LO);
    assign wr_ctl_two = req.wr && hit(req.addr, swppm_pkg::OFS_CTL_TWO);
    assign rd_stat = req.rd && hit(req.addr, swppm_pkg::OFS_STAT_ONE);
    assign rd_data = req.rd && hit(req.addr, swppm_pkg::OFS_DATA_LO);
    assign bus_mode = ctl_one_r[swppm_pkg::CTL1_BUS_MODE];
    assign modulus = BR_W'({baud_hi_r[swppm_pkg::BAUD_HI_BITS-1:0],
                            baud_lo_r});

    // a data write seizes the wire whatever is running
    assign frame_start = wr_data && bus_mode
                         && ctl_two_r[swppm_pkg::CTL2_TE];
    assign break_start = wr_ctl_two && bus_mode && !frame_start
                         && req.wdata[swppm_pkg::CTL2_SBK];

    // ------------------------------------------------------------
    // slot timing
    // ------------------------------------------------------------
    swppm_slot_timer #(
        .BR_W(BR_W)
    ) u_timer (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .run(state_r != ST_IDLE),
        .restart(frame_start || break_start),
        .modulus(modulus),
        .slot_mid(slot_mid),
        .slot_end(slot_end)
    );

    // ------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------
    assign sent_level = push_level(slot_idx_r, payload_r);
    // rx never reaches the receiver while pushing
    assign rx_path = (state_r == ST_PULL || state_r == ST_EOF)
                     ? rx_in : 1'b1;
    assign push_err = state_r == ST_PUSH && slot_mid
                      && slot_idx_r < swppm_pkg::PULL_SYNC_SLOT
                      && rx_in != sent_level;
    assign pull_done = state_r == ST_PULL && slot_end
                       && slot_idx_r == swppm_pkg::PULL_BITS - 1'b1;
    assign eof_done = state_r == ST_EOF && slot_end
                      && slot_idx_r == swppm_pkg::EOF_SLOTS - 1'b1;
    assign tdre_set = state_r == ST_PUSH && slot_end && slot_idx_r == '0;
    assign frame_end = eof_done || (state_r == ST_BREAK && slot_end
                       && slot_idx_r == swppm_pkg::BREAK_SLOTS - 1'b1);

    // leaving bus mode drops any frame at once
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            slot_idx_r <= '0;
        end else if (!bus_mode) begin
            state_r <= ST_IDLE;
            slot_idx_r <= '0;
        end else if (frame_start) begin
            state_r <= ST_PUSH;
            slot_idx_r <= '0;
        end else if (break_start) begin
            state_r <= ST_BREAK;
            slot_idx_r <= '0;
        end else if (slot_end) begin
            unique case (state_r)
                ST_IDLE: begin
                    slot_idx_r <= '0;
                end
                ST_PUSH: begin
                    if (slot_idx_r == swppm_pkg::LAST_PUSH_SLOT) begin
                        state_r <= ST_PULL;
                        slot_idx_r <= '0;
                    end else begin
                        slot_idx_r <= slot_idx_r + 1'b1;
                    end
                end
                ST_PULL: begin
                    if (pull_done) begin
                        state_r <= ST_EOF;
                        slot_idx_r <= '0;
                    end else begin
                        slot_idx_r <= slot_idx_r + 1'b1;
                    end
                end
                ST_EOF, ST_BREAK: begin
                    if (frame_end) begin
                        state_r <= ST_IDLE;
                        slot_idx_r <= '0;
                    end else begin
                        slot_idx_r <= slot_idx_r + 1'b1;
                    end
                end
            endcase
        end
    end

    // wire level changes on slot boundaries, or at once when bus mode drops; recessive when idle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tx_r <= 1'b1;
        end else if (!bus_mode) begin
            tx_r <= 1'b1;
        end else if (frame_start || break_start) begin
            tx_r <= ctl_one_r[swppm_pkg::CTL1_TX_INV];
        end else if (state_r == ST_BREAK && !frame_end) begin
            tx_r <= ctl_one_r[swppm_pkg::CTL1_TX_INV];
        end else if (state_r == ST_PUSH && slot_end) begin
            if (slot_idx_r == swppm_pkg::LAST_PUSH_SLOT) begin
                tx_r <= ~ctl_one_r[swppm_pkg::CTL1_TX_INV];
            end else begin
                tx_r <= ctl_one_r[swppm_pkg::CTL1_TX_INV]
                        ^ push_level(slot_idx_r + 1'b1, payload_r);
            end
        end else if (state_r != ST_PUSH) begin
            tx_r <= ~ctl_one_r[swppm_pkg::CTL1_TX_INV];
        end
    end

    // pull bits arrive least significant first
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            shift_r <= '0;
        end else if (state_r == ST_PULL && slot_mid) begin
            shift_r <= {rx_path, shift_r[7:1]};
        end
    end

    // the end-of-frame wave should flip every slot
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            eof_prev_r <= 1'b1;
            eof_high_r <= 1'b1;
            eof_edges_r <= '0;
        end else if (pull_done) begin
            eof_prev_r <= shift_r[7];
            eof_high_r <= 1'b1;
            eof_edges_r <= '0;
        end else if (state_r == ST_EOF && slot_mid) begin
            eof_prev_r <= rx_path;
            eof_high_r <= eof_high_r && rx_path;
            if (rx_path != eof_prev_r && eof_edges_r != 4'hF) begin
                eof_edges_r <= eof_edges_r + 1'b1;
            end
        end
    end

    // verdict on the finished frame, cleared by the next one
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            frame_ok_r <= 1'b0;
            frame_fail_r <= 1'b0;
        end else if (frame_start) begin
            frame_ok_r <= 1'b0;
            frame_fail_r <= 1'b0;
        end else if (eof_done) begin
            frame_ok_r <= rx_data_r != swppm_pkg::PULL_ONES
                          && rx_data_r != swppm_pkg::PULL_ZEROS
                          && eof_edges_r >= swppm_pkg::EOF_MIN_EDGES;
            frame_fail_r <= rx_data_r == swppm_pkg::PULL_ONES
                            && eof_high_r;
        end
    end

    localparam logic [swppm_pkg::SLOT_W-1:0] PULL_SYNC_M1 =
        swppm_pkg::PULL_SYNC_SLOT - 6'd1;

    // receiver wakes on the pull sync slot only if enabled
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rx_active_r <= 1'b0;
        end else if (frame_start || frame_end || !bus_mode) begin
            rx_active_r <= 1'b0;
        end else if (state_r == ST_PUSH && slot_end
                     && slot_idx_r == PULL_SYNC_M1) begin
            rx_active_r <= ctl_two_r[swppm_pkg::CTL2_RE];
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            baud_hi_r <= swppm_pkg::BAUD_HI_RST;
            baud_lo_r <= swppm_pkg::BAUD_LO_RST;
            ctl_one_r <= swppm_pkg::CTL_RST;
        end else if (req.wr) begin
            if (hit(req.addr, swppm_pkg::OFS_BAUD_HI)) begin
                baud_hi_r <= req.wdata;
            end
            if (hit(req.addr, swppm_pkg::OFS_BAUD_LO)) begin
                baud_lo_r <= req.wdata;
            end
            if (hit(req.addr, swppm_pkg::OFS_CTL_ONE)) begin
                ctl_one_r <= req.wdata;
            end
        end
    end

    // the break bit reads back set until its 20 slots are over
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctl_two_r <= swppm_pkg::CTL_RST;
        end else if (wr_ctl_two) begin
            ctl_two_r <= req.wdata;
        end else if (state_r == ST_BREAK && frame_end) begin
            ctl_two_r[swppm_pkg::CTL2_SBK] <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            payload_r <= '0;
        end else if (wr_data) begin
            payload_r <= req.wdata;
        end
    end

    // pull byte lands only when the receiver was woken
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rx_data_r <= '0;
        end else if (pull_done && rx_active_r) begin
            rx_data_r <= shift_r; // all eight samples are in
        end
    end

    // transmit side flags follow the data write, the end of push slot 0 (TDRE) and the frame end (TC, IDLE)
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tdre_r <= swppm_pkg::STAT_ONE_RST[swppm_pkg::ST1_TDRE];
            tc_r <= swppm_pkg::STAT_ONE_RST[swppm_pkg::ST1_TC];
            idle_r <= swppm_pkg::STAT_ONE_RST[swppm_pkg::ST1_IDLE];
        end else if (wr_data) begin
            tdre_r <= !bus_mode || !ctl_two_r[swppm_pkg::CTL2_TE];
            tc_r <= 1'b0;
            idle_r <= 1'b0;
        end else begin
            if (tdre_set) begin
                tdre_r <= 1'b1;
            end
            if (frame_end) begin
                tc_r <= 1'b1;
                idle_r <= 1'b1;
            end
        end
    end

    // status read arms the clear; the data read clears what was seen
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdrf_snap_r <= 1'b0;
            mismatch_snap_r <= 1'b0;
        end else if (rd_stat) begin
            rdrf_snap_r <= rdrf_r;
            mismatch_snap_r <= mismatch_r;
        end else if (rd_data) begin
            rdrf_snap_r <= 1'b0;
            mismatch_snap_r <= 1'b0;
        end
    end

    // a new event in the clearing cycle wins over the clear
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdrf_r <= 1'b0;
            mismatch_r <= 1'b0;
        end else begin
            if (pull_done && rx_active_r) begin
                rdrf_r <= 1'b1;
            end else if (rd_data && rdrf_snap_r) begin
                rdrf_r <= 1'b0;
            end
            if (push_err) begin
                mismatch_r <= 1'b1;
            end else if (rd_data && mismatch_snap_r) begin
                mismatch_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read port: data valid only in the cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= '0;
        end else if (!req.rd) begin
            rdata_r <= '0;
        end else begin
            unique case (req.addr)
                swppm_pkg::OFS_BAUD_HI: rdata_r <= baud_hi_r;
                swppm_pkg::OFS_BAUD_LO: rdata_r <= baud_lo_r;
                swppm_pkg::OFS_CTL_ONE: rdata_r <= ctl_one_r;
                swppm_pkg::OFS_CTL_TWO: rdata_r <= ctl_two_r;
                swppm_pkg::OFS_STAT_ONE: begin
                    rdata_r <= {tdre_r, tc_r, rdrf_r, idle_r,
                                1'b0, mismatch_r, 2'b00};
                end
                swppm_pkg::OFS_STAT_TWO: begin
                    rdata_r <= {5'b00000, frame_fail_r, frame_ok_r,
                                rx_active_r};
                end
                swppm_pkg::OFS_DATA_LO: rdata_r <= rx_data_r;
                default: rdata_r <= '0; // unmapped and data high read zero
            endcase
        end
    end

    assign rdata = rdata_r;
    assign tx_out = tx_r;

endmodule : swppm_top
`default_nettype wire
